//--- interval_timer.sv
// quarter-second prescaler and period counter of the watchdog
// assumes restart and enable synchronous to hclk
module interval_timer #(
   parameter int unsigned BASE_CYCLES = 25000000
) (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       clk_en,
   input  wire logic       run,
   input  wire logic       restart,
   input  wire logic [3:0] periods,
   output logic            overflow
);
   localparam int PW = $clog2(BASE_CYCLES);
   logic [PW-1:0] pre_q, pre_d;
   logic [3:0]    per_q, per_d;
   logic          ovf_q, ovf_d;
   logic          tick;

   assign tick = (pre_q == PW'(BASE_CYCLES - 1));

   // prescale the clock to base periods and count them
   always_comb begin
      pre_d = pre_q;
      per_d = per_q;
      ovf_d = 1'b0;
      if (restart || !run) begin
         pre_d = '0;
         per_d = '0;
      end else if (tick) begin
         pre_d = '0;
         if (per_q + 4'h1 >= periods) begin
            per_d = '0;
            ovf_d = 1'b1;
         end else begin
            per_d = per_q + 4'h1;
         end
      end else begin
         pre_d = pre_q + PW'(1);
      end
   end

   // registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_q <= '0;
         per_q <= 4'h0;
         ovf_q <= 1'b0;
      end else if (clk_en) begin
         pre_q <= pre_d;
         per_q <= per_d;
         ovf_q <= ovf_d;
      end
   end

   assign overflow = ovf_q;
endmodule : interval_timer

//--- stretch_counter.sv
// counter that holds a reset for a fixed number of cycles after its trigger drops
// assumes a synchronous trigger on hclk
module stretch_counter
   import wdt_pkg::*;
#(
   parameter int unsigned HOLD = 144
) (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic clk_en,
   input  wire logic trigger,
   output logic      hold_active
);
   localparam int W = $clog2(HOLD + 1);
   lvr_state_e   state_q, state_d;
   logic [W-1:0] cnt_q, cnt_d;

   // low supply holds reset, then counts the stretch
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         LVR_IDLE: begin
            if (trigger) state_d = LVR_LOW;
         end
         LVR_LOW: begin
            cnt_d = '0;
            if (!trigger) state_d = LVR_HOLD;
         end
         LVR_HOLD: begin
            if (trigger) state_d = LVR_LOW;
            else if (cnt_q == W'(HOLD - 1)) state_d = LVR_IDLE;
            else cnt_d = cnt_q + W'(1);
         end
         default: state_d = LVR_IDLE;
      endcase
   end

   // registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= LVR_IDLE;
         cnt_q   <= '0;
      end else if (clk_en) begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   assign hold_active = (state_q != LVR_IDLE);
endmodule : stretch_counter

//--- testbench.sv
// self-checking bench for the watchdog and low-supply reset block
// assumes zero wait states and a base period cut to ten cycles
`include "wdt_cfg.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [11:0] CTL = `WDT_CTRL_ADDR;
   localparam logic [11:0] STA = `WDT_STATUS_ADDR;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, clk_en = 1, supply_low = 0, isp_mode = 0;
   logic        hreadyout, hresp, chip_reset;
   logic [11:0] haddr = 0;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 0, hrdata, rd;
   int          bad_count = 0, n_checks = 0, pulses = 0, c, n, p;
   wire         hready = hreadyout;
   watchdog_and_low_voltage_reset #(.BASE_CYCLES(10), .LVR_HOLD(144)) dut (.*);
   // clock
   initial forever #5 hclk = ~hclk;
   // count cycles with chip reset high
   always @(posedge hclk) if (chip_reset === 1'h1) pulses++;
   task chk(string s, logic [31:0] got, logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s exp %h got %h", s, exp, got);
      end
   endtask : chk
   // one single transfer; read data lands in rd
   task xfer(logic w, logic [11:0] a, logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      do @(posedge hclk); while (hready !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'h1);
      rd = hrdata;
   endtask : xfer
   task results;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : results
   // hang limit
   initial begin
      #100us;
      bad_count++;
      results();
   end
   // test sequence
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'h1;
      repeat (200) @(posedge hclk);
      chk("idle", pulses, 0);
      xfer(0, CTL, 0);
      chk("ctrl read", rd, 0);
      xfer(0, 12'h004, 0);
      chk("unmapped", rd, 0);
      for (int f = 0; f < 8; f++) begin
         n = 10 * ((f == 0) ? 8 : f);
         xfer(1, CTL, 32'h80 | f);
         c = 0;
         while (chip_reset !== 1'h1 && c < 200) begin
            @(posedge hclk);
            c++;
         end
         chk("interval", c >= n - 2 && c <= n + 4, 1);
         xfer(1, CTL, 0);
      end
      p = pulses;
      xfer(1, CTL, 32'h82);
      xfer(0, STA, 0);
      chk("status", rd, 32'h6);
      repeat (6) begin
         repeat (8) @(posedge hclk);
         xfer(1, CTL, 32'hc2);
      end
      chk("restart", pulses, p);
      repeat (30) @(posedge hclk);
      chk("overflow", pulses, p + 1);
      xfer(1, CTL, 0);
      isp_mode <= 1'h1;
      xfer(1, CTL, 32'h81);
      repeat (40) @(posedge hclk);
      chk("isp", pulses, p + 1);
      xfer(1, CTL, 32'h80);
      isp_mode <= 1'h0;
      supply_low <= 1'h1;
      repeat (5) @(posedge hclk);
      chk("low supply", chip_reset, 1);
      xfer(0, STA, 0);
      chk("lvr status", rd, 32'h8);
      supply_low <= 1'h0;
      repeat (140) @(posedge hclk);
      chk("hold", chip_reset, 1);
      repeat (10) @(posedge hclk);
      chk("release", chip_reset, 0);
      p = pulses;
      repeat (100) @(posedge hclk);
      chk("enable cleared", pulses, p);
      // clock enable low freezes the count
      xfer(1, CTL, 32'h81);
      clk_en <= 1'h0;
      repeat (30) @(posedge hclk);
      chk("frozen", pulses, p);
      clk_en <= 1'h1;
      repeat (14) @(posedge hclk);
      chk("thawed", pulses, p + 1);
      xfer(1, CTL, 0);
      results();
   end
endmodule : testbench

//--- watchdog_and_low_voltage_reset.sv
// top of the watchdog and low-supply reset block with its AHB-Lite register slave
// assumes a single AHB-Lite master, a synchronous low-supply detector input and a 100 MHz hclk
//
// Functional notes
// - counter overflow while enabled asserts a full device reset
// - overflow interval is N times a quarter second, N from one to eight
// - three-bit interval field; zero means eight periods, else its own value
// - after power-on reset the watchdog is off until software enables it
// - writing one to the enable bit starts the watchdog counting
// - writing one to the restart bit restarts the count from zero
// - supply below threshold long enough asserts the chip reset
// - after supply recovery reset stays asserted for 144 clock cycles
// - in-system programming mode suppresses watchdog resets
//
// Decided for this implementation: register access over AHB-Lite.
`include "wdt_cfg.svh"
module watchdog_and_low_voltage_reset
   import wdt_pkg::*;
#(
   parameter int unsigned BASE_CYCLES = `WDT_BASE_CYCLES,
   parameter int unsigned LVR_HOLD    = `LVR_HOLD_CYCLES
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        clk_en,
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        supply_low,
   input  wire logic        isp_mode,
   output logic             chip_reset
);
   // address phase capture
   logic        wr_pend_q, wr_pend_d;
   logic [11:0] addr_q, addr_d;
   logic        en_q, en_d;
   logic [2:0]  int_q, int_d;
   logic        restart_q, restart_d;
   logic        wdt_rst_q, wdt_rst_d;
   logic [31:0] rdata_q, rdata_d;
   logic        take;
   logic        overflow;
   logic        lvr_active;
   logic [3:0]  periods;

   assign take = hsel && hready && htrans[1];

   // bus slave: writes land in the data phase, reads answered from a register
   always_comb begin
      wr_pend_d = take && hwrite;
      addr_d    = take ? haddr : addr_q;
      en_d      = en_q;
      int_d     = int_q;
      restart_d = 1'b0;
      rdata_d   = rdata_q;
      if (wr_pend_q && addr_q == `WDT_CTRL_ADDR) begin
         en_d      = hwdata[`WDT_EN_BIT];
         restart_d = hwdata[`WDT_RESTART_BIT];
         int_d     = hwdata[`WDT_INT_MSB:`WDT_INT_LSB];
      end
      if (take && !hwrite) begin
         if (haddr == `WDT_STATUS_ADDR)
            rdata_d = {27'h0000000, wdt_rst_q, lvr_active, en_q, int_q[1:0]} | {29'h0, int_q};
         else
            rdata_d = 32'h00000000;   // control is write-only, unmapped reads zero
      end
      if (lvr_active) en_d = 1'b0;
   end

   // bus and control registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         addr_q    <= 12'h000;
         en_q      <= 1'b0;
         int_q     <= 3'h0;
         restart_q <= 1'b0;
         rdata_q   <= 32'h00000000;
      end else if (clk_en) begin
         wr_pend_q <= wr_pend_d;
         addr_q    <= addr_d;
         en_q      <= en_d;
         int_q     <= int_d;
         restart_q <= restart_d;
         rdata_q   <= rdata_d;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_q;

   // field zero selects eight periods
   assign periods = (int_q == 3'h0) ? 4'h8 : {1'b0, int_q};

   interval_timer #(
      .BASE_CYCLES (BASE_CYCLES)
   ) u_timer (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .clk_en   (clk_en),
      .run      (en_q),
      .restart  (restart_q),
      .periods  (periods),
      .overflow (overflow)
   );

   stretch_counter #(
      .HOLD (LVR_HOLD)
   ) u_lvr (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .clk_en      (clk_en),
      .trigger     (supply_low),
      .hold_active (lvr_active)
   );

   // one-cycle watchdog reset pulse, blocked in programming mode
   always_comb begin
      wdt_rst_d = overflow && en_q && !isp_mode;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) wdt_rst_q <= 1'b0;
      else if (clk_en) wdt_rst_q <= wdt_rst_d;
   end

   assign chip_reset = wdt_rst_q | lvr_active;
endmodule : watchdog_and_low_voltage_reset

//--- wdt_cfg.svh
// register offsets, field positions and timing constants for the watchdog and low-supply reset block
// assumes a 100 MHz hclk and an AHB-Lite bus with 32-bit data
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH
`define WDT_CTRL_ADDR      12'hf18
`define WDT_STATUS_ADDR    12'hf1c
`define WDT_EN_BIT         7
`define WDT_RESTART_BIT    6
`define WDT_INT_MSB        2
`define WDT_INT_LSB        0
`define WDT_CLK_HZ         100000000
`define WDT_BASE_PERIOD_MS 250
`define WDT_BASE_CYCLES    ((`WDT_CLK_HZ / 1000) * `WDT_BASE_PERIOD_MS)
`define LVR_HOLD_CYCLES    144
`endif

//--- wdt_checker_assertions.sv
// assertions on the ports of the watchdog and low-supply reset block
// assumes clk_en high and supply_low changing only rarely
`include "wdt_cfg.svh"
module wdt_checker #(
   parameter int unsigned LVR_HOLD = 144
) (
   input wire logic        hclk, hresetn, hsel, hwrite, hready,
   input wire logic [11:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic [31:0] hwdata, hrdata,
   input wire logic        hreadyout, hresp, supply_low, isp_mode, chip_reset
);
   logic       rd_q, wr_q, en_q;
   logic [7:0] lo_q;
   wire        quiet = lo_q > 8'ha0;
   wire        take  = hsel & hready & htrans[1];
   // data phases, enable history and cycles since the supply was low
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_q <= 1'h0;
         wr_q <= 1'h0;
         en_q <= 1'h0;
         lo_q <= 8'h0;
      end else begin
         rd_q <= take & !hwrite & (haddr != `WDT_STATUS_ADDR);
         wr_q <= take & hwrite & (haddr == `WDT_CTRL_ADDR);
         en_q <= supply_low ? 1'h0 : en_q | (wr_q & hwdata[7]);
         lo_q <= supply_low ? 8'h0 : lo_q + {7'h0, lo_q != 8'hff};
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // reset still high 144 cycles after the supply recovers, then released
   sequence hold_end;
      ##144 chip_reset ##1 !chip_reset;
   endsequence
   ready_hi_a: assert property (hreadyout) else $error("wait state seen");
   resp_okay_a: assert property (!hresp) else $error("error response");
   rd_zero_a: assert property (rd_q |-> hrdata == 32'h0) else $error("nonzero read");
   lvr_rise_a: assert property ($rose(supply_low) |-> ##2 chip_reset) else $error("no reset");
   lvr_hold_a: assert property ($fell(supply_low) |-> hold_end) else $error("bad hold");
   wdt_off_a: assert property (quiet && !en_q |-> !chip_reset) else $error("reset while off");
   wdt_pulse_a: assert property (quiet && $rose(chip_reset) |=> !chip_reset) else $error("long pulse");
   isp_block_a: assert property (quiet && isp_mode && $past(isp_mode, 3) |-> !chip_reset) else $error("isp");
endmodule : wdt_checker
bind watchdog_and_low_voltage_reset wdt_checker #(.LVR_HOLD(LVR_HOLD)) chk (.hclk, .hresetn, .hsel,
   .hwrite, .hready, .haddr, .htrans, .hwdata, .hrdata, .hreadyout, .hresp, .supply_low, .isp_mode, .chip_reset);

//--- wdt_pkg.sv
// types shared by the watchdog block
// assumes nothing outside itself
package wdt_pkg;
   typedef enum logic [1:0] {
      LVR_IDLE  = 2'b00,
      LVR_LOW   = 2'b01,
      LVR_HOLD  = 2'b10
   } lvr_state_e;
endpackage : wdt_pkg
